// >>> verilog/bpo_port.sv
// Two 8-bit bidirectional ports with peripheral overrides and mode muxing
//
// The placing of the registers and the plain strobed port were decided locally.
module bpo_port
	import bpo_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Register port
	input  wire logic [3:0]    addr_i,
	input  wire logic [W-1:0]  wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [W-1:0]  rdata_o,
	// First port pins
	input  wire logic [W-1:0]  pc_in_i,
	output logic      [W-1:0]  pc_out_o,
	output logic      [W-1:0]  pc_oe_n_o,
	// First port peripheral functions, per pin
	input  wire logic [W-1:0]  pc_per_en_i,
	input  wire logic [W-1:0]  pc_per_out_i,
	input  wire logic [W-1:0]  pc_per_drive_i,
	output logic      [W-1:0]  pc_per_in_o,
	output logic               ccp2_in_o,
	input  wire logic          ccp2_en_i,
	input  wire logic          ccp2_out_i,
	input  wire logic          ccp2_drive_i,
	// Second port pins
	input  wire logic [W-1:0]  pd_in_i,
	output logic      [W-1:0]  pd_out_o,
	output logic      [W-1:0]  pd_oe_n_o,
	// External bus low byte
	input  wire logic [W-1:0]  xb_out_i,
	input  wire logic          xb_drive_i,
	output logic      [W-1:0]  xb_in_o,
	// Parallel slave handshake from outside logic
	input  wire logic          ps_rd_n_i,
	input  wire logic          ps_wr_n_i,
	input  wire logic          ps_cs_n_i,
	input  wire logic [W-1:0]  ps_out_i,
	output logic      [W-1:0]  ps_in_o,
	output logic               ps_mode_o
);
	logic [W-1:0] c_lat_q, c_dir_q, c_pin_q;
	logic [W-1:0] d_lat_q, d_dir_q, d_pin_q;
	logic [7:0]   mem_q, psp_q, cfg_q;
	logic [W-1:0] c_eff_dir, d_eff_dir;
	logic [W-1:0] c_drv, d_drv;
	logic         ccp2_on;
	bpo_dmode_e   d_mode;

	function automatic logic wr_at(input logic [3:0] a);
		wr_at = wr_i && (addr_i == a);
	endfunction

	// No reset on latch or pin sample, so contents survive resets
	always_ff @(posedge clk_i) begin
		if (wr_at(BPO_A_C_LAT) || wr_at(BPO_A_C_PIN)) begin
			c_lat_q <= wdata_i;
		end
		if (wr_at(BPO_A_D_LAT) || wr_at(BPO_A_D_PIN)) begin
			d_lat_q <= wdata_i;
		end
		c_pin_q <= pc_in_i;
		d_pin_q <= pd_in_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			c_dir_q <= BPO_DIR_RST;
			d_dir_q <= BPO_DIR_RST;
			mem_q   <= BPO_MEM_RST;
			psp_q   <= BPO_ZERO;
			cfg_q   <= BPO_CFG_RST;
		end else begin
			if (wr_at(BPO_A_C_DIR)) begin
				c_dir_q <= wdata_i;
			end
			if (wr_at(BPO_A_D_DIR)) begin
				d_dir_q <= wdata_i;
			end
			if (wr_at(BPO_A_MEM_CTRL)) begin
				mem_q <= wdata_i;
			end
			if (wr_at(BPO_A_PSP_CTRL)) begin
				psp_q <= wdata_i;
			end
			if (wr_at(BPO_A_CFG)) begin
				cfg_q <= wdata_i;
			end
		end
	end

	// Capture two lands on bit 1 only with the select bit set
	assign ccp2_on = ccp2_en_i && cfg_q[BPO_CCP2_SEL_B];

	always_comb begin
		c_eff_dir = c_dir_q;
		c_drv     = c_lat_q;
		for (int i = 0; i < W; i++) begin
			if (pc_per_en_i[i]) begin
				c_eff_dir[i] = ~pc_per_drive_i[i];
				c_drv[i]     = pc_per_out_i[i];
			end
		end
		if (ccp2_on) begin
			c_eff_dir[BPO_C_TOSI_B] = ~ccp2_drive_i;
			c_drv[BPO_C_TOSI_B]     = ccp2_out_i;
		end
	end

	// Oe low means driving: one in direction tristates
	assign pc_oe_n_o   = c_eff_dir;
	assign pc_out_o    = c_drv;
	assign pc_per_in_o = c_pin_q;
	assign ccp2_in_o   = c_pin_q[BPO_C_TOSI_B] & cfg_q[BPO_CCP2_SEL_B];

	always_comb begin
		if (!mem_q[BPO_EXT_BUS_DIS_B]) begin
			d_mode = BPO_D_EXTBUS;
		end else if (psp_q[BPO_PSP_EN_B]) begin
			d_mode = BPO_D_PSP;
		end else begin
			d_mode = BPO_D_GPIO;
		end
	end

	always_comb begin
		case (d_mode)
			BPO_D_EXTBUS: begin
				d_eff_dir = {W{~xb_drive_i}};
				d_drv     = xb_out_i;
			end
			BPO_D_PSP: begin
				// Drive only during an outside read cycle
				// A host write keeps the pins released so its data can be sampled
				d_eff_dir = {W{ps_rd_n_i | ps_cs_n_i | ~ps_wr_n_i}};
				d_drv     = ps_out_i;
			end
			default: begin
				d_eff_dir = d_dir_q;
				d_drv     = d_lat_q;
			end
		endcase
	end

	assign pd_oe_n_o = d_eff_dir;
	assign pd_out_o  = d_drv;
	assign xb_in_o   = d_pin_q;
	assign ps_in_o   = d_pin_q;
	assign ps_mode_o = (d_mode == BPO_D_PSP);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= BPO_ZERO;
		end else if (rd_i) begin
			if (addr_i == BPO_A_C_PIN) begin
				rdata_o <= c_pin_q;
			end else if (addr_i == BPO_A_C_LAT) begin
				rdata_o <= c_lat_q;
			end else if (addr_i == BPO_A_C_DIR) begin
				rdata_o <= c_dir_q;
			end else if (addr_i == BPO_A_D_PIN) begin
				rdata_o <= d_pin_q;
			end else if (addr_i == BPO_A_D_LAT) begin
				rdata_o <= d_lat_q;
			end else if (addr_i == BPO_A_D_DIR) begin
				rdata_o <= d_dir_q;
			end else if (addr_i == BPO_A_MEM_CTRL) begin
				rdata_o <= mem_q;
			end else if (addr_i == BPO_A_PSP_CTRL) begin
				rdata_o <= psp_q;
			end else if (addr_i == BPO_A_CFG) begin
				rdata_o <= cfg_q;
			end else begin
				rdata_o <= BPO_ZERO;
			end
		end else begin
			rdata_o <= BPO_ZERO;
		end
	end

	property p_dir_in;
		@(posedge clk_i) disable iff (rst_i)
		(pc_per_en_i == BPO_ZERO && !ccp2_en_i) |-> pc_oe_n_o == c_dir_q;
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("tristate not per direction");

	property p_drive_lat;
		@(posedge clk_i) disable iff (rst_i)
		(pc_per_en_i == BPO_ZERO && !ccp2_en_i) |-> (pc_out_o & ~c_dir_q) == (c_lat_q & ~c_dir_q);
	endproperty
	a_drive_lat: assert property (p_drive_lat) else $error("latch not on pins");

	property p_lat_rb;
		@(posedge clk_i) disable iff (rst_i)
		(wr_i && addr_i == BPO_A_C_LAT) ##1 (rd_i && addr_i == BPO_A_C_LAT && !wr_i)
		|=> rdata_o == $past(wdata_i, 2);
	endproperty
	a_lat_rb: assert property (p_lat_rb) else $error("latch readback wrong");

	property p_dir_rst;
		@(posedge clk_i) $fell(rst_i) |-> c_dir_q == BPO_DIR_RST && d_dir_q == BPO_DIR_RST;
	endproperty
	a_dir_rst: assert property (p_dir_rst) else $error("direction reset wrong");

	property p_override;
		@(posedge clk_i) disable iff (rst_i)
		!ccp2_on |-> (pc_oe_n_o & pc_per_en_i) == (~pc_per_drive_i & pc_per_en_i);
	endproperty
	a_override: assert property (p_override) else $error("override ignored");

	property p_dir_clean;
		@(posedge clk_i) disable iff (rst_i)
		(!wr_i || addr_i != BPO_A_C_DIR) |=> c_dir_q == $past(c_dir_q);
	endproperty
	a_dir_clean: assert property (p_dir_clean) else $error("direction changed");

	property p_ccp2;
		@(posedge clk_i) disable iff (rst_i)
		(ccp2_en_i && cfg_q[BPO_CCP2_SEL_B]) |-> pc_out_o[BPO_C_TOSI_B] == ccp2_out_i;
	endproperty
	a_ccp2: assert property (p_ccp2) else $error("capture two not on bit1");

	property p_extbus;
		@(posedge clk_i) disable iff (rst_i)
		!mem_q[BPO_EXT_BUS_DIS_B] |-> pd_out_o == xb_out_i;
	endproperty
	a_extbus: assert property (p_extbus) else $error("bus byte missing");

	property p_pinrd;
		@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == BPO_A_C_PIN) |=> rdata_o == $past(pc_in_i, 2);
	endproperty
	a_pinrd: assert property (p_pinrd) else $error("pin read wrong");

	property p_psp_rd;
		@(posedge clk_i) disable iff (rst_i)
		(ps_mode_o && !ps_cs_n_i && !ps_rd_n_i && ps_wr_n_i)
		|-> pd_oe_n_o == {W{1'b0}} && pd_out_o == ps_out_i;
	endproperty
	a_psp_rd: assert property (p_psp_rd) else $error("slave read not driven");

	// A host write must find the pins released, or the two would fight
	property p_psp_wr;
		@(posedge clk_i) disable iff (rst_i)
		(ps_mode_o && !ps_wr_n_i) |-> pd_oe_n_o == {W{1'b1}};
	endproperty
	a_psp_wr: assert property (p_psp_wr) else $error("slave write met a driver");

	property p_d_gpio;
		@(posedge clk_i) disable iff (rst_i)
		(mem_q[BPO_EXT_BUS_DIS_B] && !psp_q[BPO_PSP_EN_B]) |-> pd_oe_n_o == d_dir_q;
	endproperty
	a_d_gpio: assert property (p_d_gpio) else $error("second port not per direction");

	property p_d_lat;
		@(posedge clk_i) disable iff (rst_i)
		(mem_q[BPO_EXT_BUS_DIS_B] && !psp_q[BPO_PSP_EN_B])
		|-> (pd_out_o & ~d_dir_q) == (d_lat_q & ~d_dir_q);
	endproperty
	a_d_lat: assert property (p_d_lat) else $error("second latch not on pins");

	property p_ext_dir;
		@(posedge clk_i) disable iff (rst_i)
		!mem_q[BPO_EXT_BUS_DIS_B] |-> pd_oe_n_o == {W{~xb_drive_i}};
	endproperty
	a_ext_dir: assert property (p_ext_dir) else $error("bus direction wrong");

	property p_dir_rd;
		@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == BPO_A_C_DIR) |=> rdata_o == $past(c_dir_q);
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");

	property p_ser;
		@(posedge clk_i) disable iff (rst_i)
		(pc_per_en_i[BPO_C_TX_B] && pc_per_drive_i[BPO_C_TX_B])
		|-> pc_out_o[BPO_C_TX_B] == pc_per_out_i[BPO_C_TX_B];
	endproperty
	a_ser: assert property (p_ser) else $error("transceiver clock not on pin");

	// Read data stand one cycle only, so stale values never leak out
	property p_rd_idle;
		@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == BPO_ZERO;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data held over");

	c_psp:  cover property (@(posedge clk_i) ps_mode_o && !ps_rd_n_i && !ps_cs_n_i);
	c_ovr:  cover property (@(posedge clk_i) pc_per_en_i != BPO_ZERO);
	c_xbus: cover property (@(posedge clk_i) d_mode == BPO_D_EXTBUS && xb_drive_i);
	c_pswr: cover property (@(posedge clk_i) ps_mode_o && !ps_wr_n_i && !ps_cs_n_i);
	c_btb:  cover property (@(posedge clk_i) wr_i ##1 rd_i);
endmodule

// >>> verilog/bpo_pkg.sv
// Register map and field constants for the two-port pin block
package bpo_pkg;
	localparam int          BPO_AW            = 4;
	localparam logic [3:0]  BPO_A_C_PIN       = 4'h0;
	localparam logic [3:0]  BPO_A_C_LAT       = 4'h1;
	localparam logic [3:0]  BPO_A_C_DIR       = 4'h2;
	localparam logic [3:0]  BPO_A_D_PIN       = 4'h3;
	localparam logic [3:0]  BPO_A_D_LAT       = 4'h4;
	localparam logic [3:0]  BPO_A_D_DIR       = 4'h5;
	localparam logic [3:0]  BPO_A_MEM_CTRL    = 4'h6;
	localparam logic [3:0]  BPO_A_PSP_CTRL    = 4'h7;
	localparam logic [3:0]  BPO_A_CFG         = 4'h8;
	localparam logic [7:0]  BPO_DIR_RST       = 8'hff;
	localparam logic [7:0]  BPO_ZERO          = 8'h00;
	localparam int          BPO_EXT_BUS_DIS_B = 7;
	localparam int          BPO_PSP_EN_B      = 4;
	localparam int          BPO_CCP2_SEL_B    = 0;
	localparam logic [7:0]  BPO_MEM_RST       = 8'h80;
	localparam logic [7:0]  BPO_CFG_RST       = 8'h01;
	localparam int          BPO_C_TOSO_B      = 0;
	localparam int          BPO_C_TOSI_B      = 1;
	localparam int          BPO_C_CCP1_B      = 2;
	localparam int          BPO_C_SCK_B       = 3;
	localparam int          BPO_C_SDI_B       = 4;
	localparam int          BPO_C_SDO_B       = 5;
	localparam int          BPO_C_TX_B        = 6;
	localparam int          BPO_C_RX_B        = 7;
	typedef enum logic [1:0] {BPO_D_GPIO, BPO_D_EXTBUS, BPO_D_PSP} bpo_dmode_e;
endpackage

// >>> bench/bpo_board.sv
// Board model: each pin shows its driver, or the outside level when released
module bpo_board #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] out_i,
	input  wire logic [W-1:0] oe_n_i,
	input  wire logic [W-1:0] ext_i,
	output logic      [W-1:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pins never hold the last driven value
	assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// >>> bench/test_bidir_port_with_overrides.sv
// Self-checking bench for the two-port pin block
module test_bidir_port_with_overrides;
	timeunit 1ns;
	timeprecision 1ps;
	import bpo_pkg::*;
	logic       clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, xb_drive_i = 0;
	logic       ccp2_en_i = 0, ccp2_out_i = 0, ccp2_drive_i = 0, ps_mode_o;
	logic       ps_rd_n_i = 1, ps_wr_n_i = 1, ps_cs_n_i = 1;
	logic [3:0] addr_i = 0;
	logic [7:0] wdata_i = 0, rdata_o, pc_out_o, pc_oe_n_o, pc_pin, pd_out_o, pd_oe_n_o, pd_pin;
	logic [7:0] pc_per_en_i = 0, pc_per_out_i = 0, pc_per_drive_i = 0, xb_out_i = 0;
	logic [7:0] ps_out_i = 0, pc_ext = 8'h3c, pd_ext = 8'hc6;
	logic [7:0] pc_per_in_o, xb_in_o, ps_in_o;
	logic       ccp2_in_o;
	int         fail_count = 0, n_tests = 0, cyc = 0;

	always #4 clk_i = ~clk_i;

	bpo_board u_bc (.out_i(pc_out_o), .oe_n_i(pc_oe_n_o), .ext_i(pc_ext), .pin_o(pc_pin));
	bpo_board u_bd (.out_i(pd_out_o), .oe_n_i(pd_oe_n_o), .ext_i(pd_ext), .pin_o(pd_pin));

	bpo_port u_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.pc_in_i(pc_pin), .pc_out_o, .pc_oe_n_o, .pc_per_en_i, .pc_per_out_i,
		.pc_per_drive_i, .pc_per_in_o, .ccp2_in_o, .ccp2_en_i, .ccp2_out_i, .ccp2_drive_i,
		.pd_in_i(pd_pin), .pd_out_o, .pd_oe_n_o, .xb_out_i, .xb_drive_i, .xb_in_o,
		.ps_rd_n_i, .ps_wr_n_i, .ps_cs_n_i, .ps_out_i, .ps_in_o, .ps_mode_o);

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, well above the fewer than one hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask

	// Write then read back with no gap, read data checked where they stand
	task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, d);
	endtask

	task automatic t_reset();
		rd(BPO_A_C_DIR, BPO_DIR_RST);
		rd(BPO_A_D_DIR, BPO_DIR_RST);
		rd(BPO_A_MEM_CTRL, BPO_MEM_RST);
		rd(BPO_A_CFG, BPO_CFG_RST);
		rd(4'hf, BPO_ZERO);
		chk(pc_oe_n_o, 8'hff);
		$display("reset values done");
	endtask

	task automatic t_dir();
		wr(BPO_A_C_LAT, 8'ha5);
		wr(BPO_A_C_DIR, 8'h0f);
		#1 chk(pc_oe_n_o, 8'h0f);
		chk(pc_out_o & 8'hf0, 8'ha0);
		rd(BPO_A_C_LAT, 8'ha5);
		rd(BPO_A_C_PIN, 8'hac);
		wr(BPO_A_C_PIN, 8'h66);
		rd(BPO_A_C_LAT, 8'h66);
		wr_rd(BPO_A_C_LAT, 8'h99);
		$display("direction and latch done");
	endtask

	task automatic t_ovr();
		@(posedge clk_i);
		pc_per_en_i    <= 8'h43;
		pc_per_drive_i <= 8'h41;
		pc_per_out_i   <= 8'h41;
		wr(BPO_A_C_DIR, 8'hfd);
		#1 chk(pc_oe_n_o, 8'hbe);
		chk(pc_out_o & 8'h41, 8'h41);
		rd(BPO_A_C_DIR, 8'hfd);
		chk(pc_per_in_o, 8'h7d);
		@(posedge clk_i);
		pc_per_en_i  <= 8'h00;
		ccp2_en_i    <= 1'b1;
		ccp2_drive_i <= 1'b1;
		ccp2_out_i   <= 1'b1;
		wr(BPO_A_C_DIR, 8'hff);
		#1 chk(pc_oe_n_o, 8'hfd);
		chk(pc_out_o & 8'h02, 8'h02);
		@(posedge clk_i);
		#1 chk({7'h00, ccp2_in_o}, 8'h01);
		@(posedge clk_i);
		ccp2_en_i <= 1'b0;
		$display("overrides done");
	endtask

	task automatic t_port_d_pin_level();
		wr(BPO_A_D_LAT, 8'h5a);
		wr(BPO_A_D_DIR, 8'h00);
		#1 chk(pd_out_o, 8'h5a);
		chk(pd_oe_n_o, 8'h00);
		@(posedge clk_i);
		xb_drive_i <= 1'b1;
		xb_out_i   <= 8'hc3;
		wr(BPO_A_MEM_CTRL, 8'h00);
		#1 chk(pd_out_o, 8'hc3);
		wr(BPO_A_MEM_CTRL, 8'h80);
		xb_drive_i <= 1'b0;
		#1 chk(xb_in_o, 8'hc3);
		wr(BPO_A_PSP_CTRL, 8'h10);
		#1 chk({7'h00, ps_mode_o}, 8'h01);
		@(posedge clk_i);
		ps_cs_n_i <= 1'b0;
		ps_rd_n_i <= 1'b0;
		ps_out_i  <= 8'h99;
		@(posedge clk_i);
		#1 chk(pd_out_o, 8'h99);
		chk(pd_oe_n_o, 8'h00);
		@(posedge clk_i);
		ps_rd_n_i <= 1'b1;
		ps_wr_n_i <= 1'b0;
		@(posedge clk_i);
		#1 chk(pd_oe_n_o, 8'hff);
		chk(ps_in_o, 8'hc6);
		@(posedge clk_i);
		ps_cs_n_i <= 1'b1;
		ps_wr_n_i <= 1'b1;
		$display("second port modes done");
	endtask

	task automatic t_warm();
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		rd(BPO_A_C_LAT, 8'h99);
		rd(BPO_A_D_LAT, 8'h5a);
		rd(BPO_A_D_DIR, BPO_DIR_RST);
		rd(BPO_A_PSP_CTRL, BPO_ZERO);
		$display("second reset done");
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_dir();
		t_ovr();
		t_port_d_pin_level();
		t_warm();
		stop_test();
	end
endmodule
